// >>> verilog/ebt_params.svh
/*
  Address map, field positions and reset values of the two-channel
  8-bit compare-match timer. Assumes a 32-bit AXI4-Lite register bus.
*/
`ifndef EBT_PARAMS_SVH
`define EBT_PARAMS_SVH
`define EBT_OFF_CNT     3'h0
`define EBT_OFF_CORA    3'h1
`define EBT_OFF_CORB    3'h2
`define EBT_OFF_CTL     3'h3
`define EBT_OFF_FLG     3'h4
`define EBT_OFF_ISTAT   3'h0
`define EBT_OFF_IMASK   3'h1
`define EBT_CH_BIT      5
`define EBT_GLB_BIT     6
`define EBT_CTL_IEB     7
`define EBT_CTL_IEA     6
`define EBT_CTL_IEW     5
`define EBT_CTL_CCL_LO  3
`define EBT_CTL_CKS_LO  0
`define EBT_FLG_B       7
`define EBT_FLG_A       6
`define EBT_FLG_W       5
`define EBT_FLG_TRIG_EN 4
`define EBT_RST_CNT     8'h00
`define EBT_RST_COR     8'hff
`define EBT_RST_CTL     8'h00
`define EBT_RST_FLG     3'h0
`define EBT_DIV_A       8
`define EBT_DIV_B       64
`define EBT_DIV_C       8192
`define EBT_RESP_OK     2'h0
`define EBT_RESP_ERR    2'h2
`endif

// >>> verilog/ebt_pkg.sv
/*
  Types of the two-channel 8-bit compare-match timer.
  Enum encodings are set here; other numeric constants come from ebt_params.svh.
*/
package ebt_pkg;
  typedef enum logic [1:0] {
    EBT_CKS_STOP = 2'h0,
    EBT_CKS_DA   = 2'h1,
    EBT_CKS_DB   = 2'h2,
    EBT_CKS_DC   = 2'h3
  } ebt_cks_e;
  typedef enum logic [1:0] {
    EBT_CCL_NONE = 2'h0,
    EBT_CCL_A    = 2'h1,
    EBT_CCL_B    = 2'h2,
    EBT_CCL_RSV  = 2'h3
  } ebt_ccl_e;
  typedef logic [1:0] ebt_ch_t;
endpackage

// >>> verilog/ebt_timer.sv
/*
  Two-channel 8-bit compare-match timer: counters, compare registers,
  flags, interrupt and transfer requests, A/D start trigger, and an
  AXI4-Lite register slave. Assumes one clock, aclk, and synchronous
  active-low reset; transfer acknowledges come from logic on aclk.
*/
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ebt_params.svh"

// How it works
// - Three gated requests per channel: A, B, wrap
// - Match A/B requests also start transfers
// - Fixed priority ch0 A,B,wrap then ch1
// - Only channel 0 match A drives ADC
// - Match A with trigger enable starts ADC
// - Clear beats a counter write
// - Counter write beats a count pulse
// - Compare write suppresses its match
// - Count on falling edge of divided clock
// - Select change high-to-low counts once
// - Clear select 01 clears on match A
// - Both match enables give both interrupts
// - Equal counter sets match A/B flag
// - Flag clears by read-one then write-zero
// - Transfer activation clears flag unless transfer_irq_select is set
// - Wrap FF to 00 sets wrap flag
module ebt_timer #(
  parameter int DIV_A = `EBT_DIV_A,
  parameter int DIV_B = `EBT_DIV_B,
  parameter int DIV_C = `EBT_DIV_C
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  output ebt_pkg::ebt_ch_t  match_a_irq,
  output ebt_pkg::ebt_ch_t  match_b_irq,
  output ebt_pkg::ebt_ch_t  wrap_irq,
  output ebt_pkg::ebt_ch_t  xfer_req_a,
  output ebt_pkg::ebt_ch_t  xfer_req_b,
  input  wire ebt_pkg::ebt_ch_t xfer_ack_a,
  input  wire ebt_pkg::ebt_ch_t xfer_ack_b,
  input  wire logic         transfer_irq_select,
  output logic [2:0]        top_source,
  output logic              top_valid,
  output logic              adc_start,
  output logic              irq
);
  import ebt_pkg::*;

  localparam int PW = $clog2(DIV_C);

  // Each divider taps one prescaler bit, so each must be a power of two above the one before
  if (DIV_A < 2 || (DIV_A & (DIV_A - 1)) != 0) begin : g_bad_div_a
    $error("ebt_timer: DIV_A must be a power of two of at least 2");
  end
  if (DIV_B <= DIV_A || (DIV_B & (DIV_B - 1)) != 0) begin : g_bad_div_b
    $error("ebt_timer: DIV_B must be a power of two above DIV_A");
  end
  if (DIV_C <= DIV_B || (DIV_C & (DIV_C - 1)) != 0) begin : g_bad_div_c
    $error("ebt_timer: DIV_C must be a power of two above DIV_B");
  end

  // Divided clock level; a stopped selection reads as low
  function automatic logic sel_level(input ebt_cks_e sel, input logic [PW-1:0] p);
    logic l;
    l = 1'b0;
    unique case (sel)
      EBT_CKS_STOP: l = 1'b0;
      EBT_CKS_DA:   l = p[$clog2(DIV_A)-1];
      EBT_CKS_DB:   l = p[$clog2(DIV_B)-1];
      EBT_CKS_DC:   l = p[PW-1];
    endcase
    return l;
  endfunction

  // Word decode: bit 7 must be clear, bit 6 picks the global pair, bit 5 the channel
  function automatic logic hit(input logic [7:0] a,
                               input logic       g,
                               input logic       ch,
                               input logic [2:0] idx);
    return a[`EBT_GLB_BIT] == g && a[`EBT_CH_BIT] == ch && a[4:2] == idx && a[7] == 1'b0;
  endfunction

  // AXI4-Lite slave. Address and data are taken in either order and held until
  // both are in; the write then lands in one cycle and the response follows it.
  // Reads answer one cycle after the address is taken, from the live registers.
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_full_r;
  logic        w_full_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire wr_go  = aw_full_r & w_full_r & ~bvalid_r;
  wire rd_go  = s_axi_arvalid & ~rvalid_r;
  wire aw_hs  = s_axi_awvalid & s_axi_awready;
  wire w_hs   = s_axi_wvalid & s_axi_wready;
  wire wr_lo  = wr_go & wstrb_r[0];
  wire [7:0] wbyte = wdata_r[7:0];

  assign s_axi_awready = ~aw_full_r & ~bvalid_r;
  assign s_axi_wready  = ~w_full_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  logic [PW-1:0] presc_r;
  logic [5:0]    istat_r;
  logic [5:0]    imask_r;
  logic [5:0]    events;
  logic [5:0]    req;
  logic [31:0]   ch_rd [2];
  logic          mat_a_ch0;
  logic          adc_trigger_enable_r;

  // Unmapped words answer with an error unless a write leaves byte 0 unstrobed, and leave every register as it was
  wire wr_istat = wr_lo & hit(awaddr_r, 1'b1, 1'b0, `EBT_OFF_ISTAT);
  wire wr_imask = wr_lo & hit(awaddr_r, 1'b1, 1'b0, `EBT_OFF_IMASK);
  wire rd_istat = hit(s_axi_araddr, 1'b1, 1'b0, `EBT_OFF_ISTAT);
  wire rd_imask = hit(s_axi_araddr, 1'b1, 1'b0, `EBT_OFF_IMASK);
  wire rd_ch    = ~s_axi_araddr[`EBT_GLB_BIT] & ~s_axi_araddr[7] & (s_axi_araddr[4:2] <= `EBT_OFF_FLG);
  wire rd_ok    = rd_istat | rd_imask | rd_ch;
  wire wr_ch    = ~awaddr_r[`EBT_GLB_BIT] & ~awaddr_r[7] & (awaddr_r[4:2] <= `EBT_OFF_FLG);
  wire wr_ok    = wr_istat | wr_imask | wr_ch | ~wstrb_r[0];
  wire [31:0] rd_val = rd_istat ? {26'h0, istat_r} :
                       rd_imask ? {26'h0, imask_r} :
                       rd_ch    ? ch_rd[s_axi_araddr[`EBT_CH_BIT]] : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_full_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      if (w_hs) begin
        w_full_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `EBT_RESP_OK;
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= `EBT_RESP_OK;
    end else begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok ? `EBT_RESP_OK : `EBT_RESP_ERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_val;
        rresp_r  <= rd_ok ? `EBT_RESP_OK : `EBT_RESP_ERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Free-running prescaler shared by both channels
  // Never cleared by a selection change, so a switch keeps the phase of the new tap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + PW'(1);
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [7:0] cnt_r;
    logic [7:0] cora_r;
    logic [7:0] corb_r;
    logic [7:0] ctl_r;
    logic [2:0] flg_r;
    logic [2:0] seen_r;
    logic       lvl_r;

    localparam logic CHB = 1'(c);

    // Strobes of this channel: writes in the single cycle in which a write lands, the flags read when its address is taken
    wire w_cnt  = wr_lo & hit(awaddr_r, 1'b0, CHB, `EBT_OFF_CNT);
    wire w_cora = wr_lo & hit(awaddr_r, 1'b0, CHB, `EBT_OFF_CORA);
    wire w_corb = wr_lo & hit(awaddr_r, 1'b0, CHB, `EBT_OFF_CORB);
    wire w_ctl  = wr_lo & hit(awaddr_r, 1'b0, CHB, `EBT_OFF_CTL);
    wire w_flg  = wr_lo & hit(awaddr_r, 1'b0, CHB, `EBT_OFF_FLG);
    wire r_flg  = rd_go & hit(s_axi_araddr, 1'b0, CHB, `EBT_OFF_FLG);

    wire ebt_cks_e cks = ebt_cks_e'(ctl_r[`EBT_CTL_CKS_LO +: 2]);
    wire ebt_ccl_e ccl = ebt_ccl_e'(ctl_r[`EBT_CTL_CCL_LO +: 2]);
    // Previous level follows the selection, so a switch from high to low counts once
    wire lvl_now = sel_level(cks, presc_r);
    wire pulse   = lvl_r & ~lvl_now;
    // Match is taken on the count pulse, the last state the equality holds
    wire mat_a   = pulse & (cnt_r == cora_r) & ~w_cora;
    wire mat_b   = pulse & (cnt_r == corb_r) & ~w_corb;
    wire clr     = (ccl == EBT_CCL_A & mat_a) | (ccl == EBT_CCL_B & mat_b);
    // A pulse lost to a clear or a write never reaches 00, so it is no overflow
    wire wrap    = pulse & ~w_cnt & ~clr & (cnt_r == 8'hff);
    // Clear beats a write, and a write swallows the count pulse of its own cycle
    wire [7:0] cnt_nxt = clr ? 8'h00 :
                         w_cnt ? wbyte :
                         pulse ? cnt_r + 8'h01 : cnt_r;
    wire [2:0] set  = {mat_b, mat_a, wrap};
    // Software clears a flag only after the last flags read saw it set
    wire [2:0] wclr = w_flg ? (seen_r & ~wbyte[`EBT_FLG_B -: 3]) : 3'h0;
    // A transfer that takes the request clears its flag unless the controller keeps it
    wire [2:0] xclr = {xfer_ack_b[c] & ~transfer_irq_select,
                       xfer_ack_a[c] & ~transfer_irq_select, 1'b0};
    wire [2:0] flg_nxt = set | (flg_r & ~(wclr | xclr));

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_r  <= `EBT_RST_CNT;
        cora_r <= `EBT_RST_COR;
        corb_r <= `EBT_RST_COR;
        ctl_r  <= `EBT_RST_CTL;
        flg_r  <= `EBT_RST_FLG;
        seen_r <= 3'h0;
        lvl_r  <= 1'b0;
      end else begin
        cnt_r  <= cnt_nxt;
        cora_r <= w_cora ? wbyte : cora_r;
        corb_r <= w_corb ? wbyte : corb_r;
        ctl_r  <= w_ctl ? wbyte : ctl_r;
        flg_r  <= flg_nxt;
        seen_r <= r_flg ? flg_r : (w_flg ? 3'h0 : seen_r);
        lvl_r  <= lvl_now;
      end
    end

    wire [2:0] en = {ctl_r[`EBT_CTL_IEB], ctl_r[`EBT_CTL_IEA], ctl_r[`EBT_CTL_IEW]};
    // Priority order inside a channel is A, B, wrap
    assign req[3*(1-c) +: 3] = {flg_r[1] & en[1], flg_r[2] & en[2], flg_r[0] & en[0]};
    assign match_a_irq[c] = flg_r[1] & en[1];
    assign match_b_irq[c] = flg_r[2] & en[2];
    assign wrap_irq[c]    = flg_r[0] & en[0];
    assign xfer_req_a[c]  = match_a_irq[c];
    assign xfer_req_b[c]  = match_b_irq[c];
    assign events[3*c +: 3] = set;
    if (c == 0) begin : g_trig
      assign mat_a_ch0 = mat_a;
    end

    wire [7:0] flg_rd = {flg_r[2], flg_r[1], flg_r[0], (c == 0) ? adc_trigger_enable_r : 1'b1, 4'h0};
    assign ch_rd[c] = (s_axi_araddr[4:2] == `EBT_OFF_CNT)  ? {24'h0, cnt_r}  :
                      (s_axi_araddr[4:2] == `EBT_OFF_CORA) ? {24'h0, cora_r} :
                      (s_axi_araddr[4:2] == `EBT_OFF_CORB) ? {24'h0, corb_r} :
                      (s_axi_araddr[4:2] == `EBT_OFF_CTL)  ? {24'h0, ctl_r}  :
                      {24'h0, flg_rd};
  end

  // Trigger enable lives only in channel 0 flags register
  wire w_trig_en = wr_lo & hit(awaddr_r, 1'b0, 1'b0, `EBT_OFF_FLG);

  // One-cycle start; whether it begins a conversion is up to the converter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_trigger_enable_r <= 1'b0;
      adc_start            <= 1'b0;
    end else begin
      adc_trigger_enable_r <= w_trig_en ? wbyte[`EBT_FLG_TRIG_EN] : adc_trigger_enable_r;
      adc_start            <= mat_a_ch0 & adc_trigger_enable_r;
    end
  end

  // Global sticky event status, write one to clear; a new event wins over the clear
  // Status bit 3c+2 is match B, 3c+1 match A and 3c wrap of channel c
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_r <= 6'h00;
      imask_r <= 6'h00;
    end else begin
      istat_r <= events | (istat_r & ~(wr_istat ? wdata_r[5:0] : 6'h00));
      imask_r <= wr_imask ? wdata_r[5:0] : imask_r;
    end
  end

  // Level output: drops only when software clears the status bit or masks it
  assign irq = |(istat_r & imask_r);

  // req bit 5 is ch0 match A, bit 0 is ch1 wrap; highest bit wins
  // The encoder only reports the winner; every request line stays up on its own
  logic [2:0] top_nxt;
  always_comb begin
    top_nxt = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (req[i]) begin
        top_nxt = 3'(5 - i);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      top_source <= 3'h0;
      top_valid  <= 1'b0;
    end else begin
      top_source <= top_nxt;
      top_valid  <= |req;
    end
  end
endmodule
`default_nettype wire

// >>> dv/ebt_xfer_model.sv
/*
  Transfer controller model answering timer transfer requests.
  Assumes requests and acks share aclk; the bench gates it by enable.
*/
`timescale 1ns/1ps
`default_nettype none
module ebt_xfer_model (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             enable,
  input  wire ebt_pkg::ebt_ch_t req,
  output var  ebt_pkg::ebt_ch_t ack
);
  import ebt_pkg::*;
  // One idle cycle between acks, as a transfer in flight would leave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack <= '0;
    end else begin
      ack <= req & ~ack & {2{enable}};
    end
  end
endmodule
`default_nettype wire

// >>> dv/ebt_checker.sv
/*
  Port checker for ebt_timer.
  Assumes aclk with synchronous active-low aresetn; bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module ebt_checker (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire ebt_pkg::ebt_ch_t match_a_irq,
  input wire ebt_pkg::ebt_ch_t match_b_irq,
  input wire ebt_pkg::ebt_ch_t wrap_irq,
  input wire ebt_pkg::ebt_ch_t xfer_req_a,
  input wire ebt_pkg::ebt_ch_t xfer_req_b,
  input wire ebt_pkg::ebt_ch_t xfer_ack_a,
  input wire logic             transfer_irq_select,
  input wire logic [2:0]       top_source,
  input wire logic             top_valid,
  input wire logic             adc_start
);
  import ebt_pkg::*;
  wire logic any_req = |{match_a_irq, match_b_irq, wrap_irq};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_xfer_a_same: assert property (xfer_req_a == match_a_irq)
    else $error("transfer request A differs from match A request");
  a_xfer_b_same: assert property (xfer_req_b == match_b_irq)
    else $error("transfer request B differs from match B request");
  a_adc_pulse: assert property (adc_start |=> !adc_start)
    else $error("A/D start longer than one cycle");
  a_top_first: assert property (match_a_irq[0] && $past(match_a_irq[0]) |-> top_valid && top_source == 3'h0)
    else $error("channel 0 match A not on top");
  a_top_idle: assert property (!any_req && $past(!any_req) |-> !top_valid)
    else $error("top valid with nothing pending");
  a_top_range: assert property (top_valid |-> top_source <= 3'h5)
    else $error("top source out of range");
  a_ack_clear: assert property (xfer_ack_a[0] && !transfer_irq_select && match_a_irq[0] |=> !match_a_irq[0])
    else $error("acknowledged match A flag not cleared");
  a_ack_keep: assert property (xfer_ack_a[0] && transfer_irq_select && match_a_irq[0] |=> match_a_irq[0])
    else $error("match A flag cleared while clearing deselected");
endmodule
bind ebt_timer ebt_checker i_chk (.*);
`default_nettype wire

// >>> dv/ebt_timer_bench.sv
/*
  Self-checking bench for ebt_timer with transfer controller models.
  Assumes prescaler divides shortened to 2/4/8 and a 10 MHz aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ebt_timer_bench;
  logic             aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic             s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic             s_axi_arready, s_axi_rvalid, s_axi_rready, transfer_irq_select;
  logic             ack_en, top_valid, adc_start, irq;
  logic [7:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata, d;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, r;
  logic [2:0]       top_source;
  ebt_pkg::ebt_ch_t match_a_irq, match_b_irq, wrap_irq;
  ebt_pkg::ebt_ch_t xfer_req_a, xfer_req_b, xfer_ack_a, xfer_ack_b;
  int               failures, tests_run, adc_cnt;

  ebt_timer #(.DIV_A(2), .DIV_B(4), .DIV_C(8)) i_dut (.*);
  ebt_xfer_model i_xa (.aclk(aclk), .aresetn(aresetn), .enable(ack_en), .req(xfer_req_a), .ack(xfer_ack_a));
  ebt_xfer_model i_xb (.aclk(aclk), .aresetn(aresetn), .enable(ack_en), .req(xfer_req_b), .ack(xfer_ack_b));

  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end
  // Counted mid-cycle so the registered pulse is settled
  always @(negedge aclk) begin
    // The bench plays a converter that always has the timer selected as start source
    if (adc_start === 1'h1) adc_cnt++;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw || w) begin
      @(negedge aclk);
      aw = aw && s_axi_awready !== 1'h1;
      w = w && s_axi_wready !== 1'h1;
      @(posedge aclk);
      if (!aw) s_axi_awvalid <= 1'h0;
      if (!w) s_axi_wvalid <= 1'h0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
    // bready stays up between writes, so a following call never lowers and raises it in one step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge aclk); while (s_axi_arready !== 1'h1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask

  task automatic t_match;
    rd(8'h30);
    chk(d, 32'h10);
    rd(8'h18);
    chk(r, 2'h2);
    wr(8'h04, 8'h03);
    wr(8'h08, 8'h01);
    wr(8'h0c, 8'hc9);
    wt(600);
    chk(match_a_irq[0], 1'h1);
    chk(match_b_irq[0], 1'h1);
    chk(xfer_req_b[0], 1'h1);
    chk(adc_cnt, 0);
    wr(8'h0c, 8'hc8);
    rd(8'h00);
    chk(d < 32'h4, 1'h1);
    rd(8'h10);
    chk(d, 32'hc0);
    wr(8'h10, 8'hc0);
    wr(8'h10, 8'h00);
    rd(8'h10);
    chk(d, 32'hc0);
    wr(8'h10, 8'h00);
    rd(8'h10);
    chk(d, 32'h0);
    chk(match_a_irq[0], 1'h0);
  endtask
  task automatic t_adc;
    wr(8'h10, 8'h10);
    wr(8'h24, 8'h02);
    wr(8'h2c, 8'h09);
    adc_cnt = 0;
    wt(100);
    chk(adc_cnt, 0);
    wr(8'h04, 8'h02);
    wr(8'h0c, 8'h09);
    wt(100);
    chk(adc_cnt != 0, 1'h1);
    wr(8'h0c, 8'h08);
    wr(8'h2c, 8'h08);
  endtask
  task automatic t_xfer;
    wr(8'h0c, 8'h40);
    chk(match_a_irq[0], 1'h1);
    wt(2);
    chk({top_valid, top_source}, 4'h8);
    transfer_irq_select <= 1'h1;
    ack_en <= 1'h1;
    wt(6);
    chk(match_a_irq[0], 1'h1);
    ack_en <= 1'h0;
    transfer_irq_select <= 1'h0;
    wt(1);
    ack_en <= 1'h1;
    wt(4);
    chk(match_a_irq[0], 1'h0);
    ack_en <= 1'h0;
  endtask
  task automatic t_wrap;
    wr(8'h20, 8'hfe);
    wr(8'h2c, 8'h21);
    wt(10);
    wr(8'h2c, 8'h20);
    rd(8'h30);
    chk(d[5], 1'h1);
    chk({top_valid, top_source}, 4'hd);
    wr(8'h44, 8'h08);
    chk(irq, 1'h1);
    wr(8'h44, 8'h00);
    chk(irq, 1'h0);
    wr(8'h44, 8'h08);
    wr(8'h40, 8'h08);
    chk(irq, 1'h0);
    chk(wrap_irq[1], 1'h1);
  endtask

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, transfer_irq_select, ack_en, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_match;
    t_adc;
    t_xfer;
    t_wrap;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    print_verdict;
  end
endmodule
`default_nettype wire
